// ==== design/dipc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the power-mode control block
`ifndef DIPC_CFG_SVH
`define DIPC_CFG_SVH
`define DIPC_OFF_VREG 12'h000
`define DIPC_OFF_SLOW 12'h004
`define DIPC_OFF_STAT 12'h008
`define DIPC_VREG_PM_BIT 1
`define DIPC_VREG_RSVD_BIT 0
`define DIPC_VREG_RESET 8'h01
`define DIPC_SLOW_IDLE_BIT 7
`define DIPC_SLOW_EN_BIT 6
`define DIPC_SLOW_ROI_BIT 5
`define DIPC_SLOW_SOR_BIT 4
`define DIPC_SLOW_RATIO_HI 2
`define DIPC_SLOW_RESET 8'h00
`define DIPC_SLOW_MASK 8'hF7
`define DIPC_WAKE_NORM_CYC 16'h0004
`define DIPC_WAKE_LP_EXTRA_CYC 16'h0010
`endif

// ==== design/dipc_pkg.sv ====
// Types of the power-mode control block
package dipc_pkg;
   typedef enum logic [1:0] {
      DIPC_RUN,
      DIPC_IDLE,
      DIPC_SLEEP,
      DIPC_WAKE
   } dipc_state_t;
endpackage

// ==== design/dipc_power_control.sv ====
// Power-mode control: regulator mode, idle, CPU slowdown and wake delay
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "dipc_cfg.svh"
module dipc_power_control #(
   parameter int WAKE_NORM = 4,
   parameter int WAKE_LP_EXTRA = 16
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic powerOnReset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleepRequest,
   input wire logic wakeEvent,
   input wire logic interruptEntry,
   input wire logic return_from_interrupt,
   input wire logic in_circuit_debug,
   output logic cpuCycleEnable,
   output logic cpuClockRun,
   output logic periphClockRun,
   output logic regulatorLowPower,
   output logic wakeDone
);
   import dipc_pkg::*;

   logic regulatorPower_reg;
   logic idleOnSleep_reg;
   logic slowdownEn_reg;
   logic recoverOnInt_reg;
   logic slowOnReturn_reg;
   logic [2:0] ratio_reg;
   logic [7:0] slowCount_reg;
   logic [15:0] wakeCount_reg;
   logic lpSleep_reg;
   dipc_state_t state_reg;
   logic setup;
   logic wrAccess;
   logic wrVreg;
   logic wrSlow;
   logic [7:0] ratioMax;
   logic [7:0] readMux;
   logic cycleNext;

   assign setup = psel && !penable;
   assign wrAccess = psel && penable && pwrite && pready;
   assign wrVreg = wrAccess && paddr == `DIPC_OFF_VREG;
   assign wrSlow = wrAccess && paddr == `DIPC_OFF_SLOW;
   assign ratioMax = 8'((9'h002 << ratio_reg) - 9'h001);

   // No wait state: ready in the first access cycle after setup
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   always_comb begin
      readMux = 8'h00;
      unique case (paddr)
         `DIPC_OFF_VREG: readMux = {6'h00, regulatorPower_reg, 1'b1};
         `DIPC_OFF_SLOW: readMux = {idleOnSleep_reg, slowdownEn_reg, recoverOnInt_reg,
            slowOnReturn_reg, 1'b0, ratio_reg};
         `DIPC_OFF_STAT: readMux = {5'h00, lpSleep_reg, state_reg};
         default: readMux = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h00000000 : {24'h000000, readMux};
         pslverr <= !(paddr == `DIPC_OFF_VREG || paddr == `DIPC_OFF_SLOW
            || paddr == `DIPC_OFF_STAT);
      end
   end

   // Regulator mode register
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regulatorPower_reg <= 1'b0;
      end else if (wrVreg) begin
         regulatorPower_reg <= pwdata[`DIPC_VREG_PM_BIT];
      end
   end

   // Idle bit survives warm resets; a power reset clears it
   always_ff @(posedge clock) begin
      if (powerOnReset) begin
         idleOnSleep_reg <= 1'b0;
      end else if (wrSlow && !sys_rst) begin
         idleOnSleep_reg <= pwdata[`DIPC_SLOW_IDLE_BIT];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         recoverOnInt_reg <= 1'b0;
         slowOnReturn_reg <= 1'b0;
         ratio_reg <= 3'h0;
      end else if (wrSlow) begin
         recoverOnInt_reg <= pwdata[`DIPC_SLOW_ROI_BIT];
         slowOnReturn_reg <= pwdata[`DIPC_SLOW_SOR_BIT];
         ratio_reg <= pwdata[`DIPC_SLOW_RATIO_HI:0];
      end
   end

   // Hardware set and clear take priority over a software write
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         slowdownEn_reg <= 1'b0;
      end else if (interruptEntry && recoverOnInt_reg) begin
         slowdownEn_reg <= 1'b0;
      end else if (return_from_interrupt && slowOnReturn_reg) begin
         slowdownEn_reg <= 1'b1;
      end else if (wrSlow) begin
         slowdownEn_reg <= pwdata[`DIPC_SLOW_EN_BIT];
      end
   end

   // Free-running slowdown counter
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         slowCount_reg <= 8'h00;
      end else if (slowCount_reg >= ratioMax) begin
         slowCount_reg <= 8'h00;
      end else begin
         slowCount_reg <= slowCount_reg + 8'h01;
      end
   end

   always_comb begin
      cycleNext = 1'b1;
      if (slowdownEn_reg && !in_circuit_debug) begin
         cycleNext = slowCount_reg >= ratioMax;
      end
   end

   // Sleep and wake sequencing
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= DIPC_RUN;
         wakeCount_reg <= 16'h0000;
         lpSleep_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            DIPC_RUN: begin
               if (sleepRequest) begin
                  state_reg <= idleOnSleep_reg ? DIPC_IDLE : DIPC_SLEEP;
                  lpSleep_reg <= regulatorPower_reg && !idleOnSleep_reg;
               end
            end
            DIPC_IDLE: begin
               if (wakeEvent) begin
                  state_reg <= DIPC_RUN;
               end
            end
            DIPC_SLEEP: begin
               if (wakeEvent) begin
                  state_reg <= DIPC_WAKE;
                  wakeCount_reg <= lpSleep_reg ? 16'(WAKE_NORM + WAKE_LP_EXTRA)
                     : 16'(WAKE_NORM);
               end
            end
            DIPC_WAKE: begin
               if (wakeCount_reg <= 16'h0001) begin
                  state_reg <= DIPC_RUN;
                  lpSleep_reg <= 1'b0;
               end else begin
                  wakeCount_reg <= wakeCount_reg - 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cpuCycleEnable <= 1'b0;
         cpuClockRun <= 1'b0;
         periphClockRun <= 1'b0;
         regulatorLowPower <= 1'b0;
         wakeDone <= 1'b0;
      end else begin
         cpuCycleEnable <= cycleNext && state_reg == DIPC_RUN;
         cpuClockRun <= state_reg == DIPC_RUN;
         periphClockRun <= state_reg == DIPC_RUN || state_reg == DIPC_IDLE;
         regulatorLowPower <= state_reg == DIPC_SLEEP && lpSleep_reg;
         wakeDone <= state_reg == DIPC_WAKE && wakeCount_reg <= 16'h0001;
      end
   end

   property p_recover;
      @(posedge clock) disable iff (sys_rst)
      interruptEntry && recoverOnInt_reg |=> !slowdownEn_reg;
   endproperty
   a_recover: assert property (p_recover) else $error("slowdown not cleared");

   property p_return;
      @(posedge clock) disable iff (sys_rst)
      return_from_interrupt && slowOnReturn_reg && !interruptEntry |=> slowdownEn_reg;
   endproperty
   a_return: assert property (p_return) else $error("slowdown not set");

   property p_full;
      @(posedge clock) disable iff (sys_rst)
      !$past(sys_rst) && (!slowdownEn_reg || in_circuit_debug) && state_reg == DIPC_RUN
         |=> cpuCycleEnable;
   endproperty
   a_full: assert property (p_full) else $error("cpu cycle dropped");

   property p_ratio2;
      @(posedge clock) disable iff (sys_rst)
      slowdownEn_reg && !in_circuit_debug && ratio_reg == 3'h0 && cpuCycleEnable
         ##0 $stable(slowdownEn_reg) && $stable(in_circuit_debug) |=> !cpuCycleEnable;
   endproperty
   a_ratio2: assert property (p_ratio2) else $error("ratio 1:2 broken");

   property p_idle;
      @(posedge clock) disable iff (sys_rst)
      state_reg == DIPC_IDLE |=> periphClockRun && !cpuClockRun;
   endproperty
   a_idle: assert property (p_idle) else $error("idle clocks wrong");

   property p_sleep;
      @(posedge clock) disable iff (sys_rst)
      state_reg == DIPC_SLEEP |=> !periphClockRun;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");

   property p_rsvd;
      @(posedge clock) disable iff (sys_rst)
      pready && !pwrite && paddr == `DIPC_OFF_VREG |-> prdata[7:0] == {6'h00, prdata[1], 1'b1};
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");

   property p_lpwake;
      @(posedge clock) disable iff (sys_rst)
      state_reg == DIPC_SLEEP && wakeEvent && lpSleep_reg |=> !wakeDone [*8];
   endproperty
   a_lpwake: assert property (p_lpwake) else $error("wake too early");

   property p_regreset;
      @(posedge clock) $fell(sys_rst) |-> !regulatorPower_reg;
   endproperty
   a_regreset: assert property (p_regreset) else $error("regulator reset wrong");

   property p_hold;
      @(posedge clock) disable iff (sys_rst)
      interruptEntry && !recoverOnInt_reg && !return_from_interrupt && !wrSlow
         |=> $stable(slowdownEn_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("slowdown changed on entry");

   property p_keep;
      @(posedge clock) disable iff (sys_rst)
      return_from_interrupt && !slowOnReturn_reg && !interruptEntry && !wrSlow
         |=> $stable(slowdownEn_reg);
   endproperty
   a_keep: assert property (p_keep) else $error("slowdown changed on return");

   property p_debug;
      @(posedge clock) disable iff (sys_rst)
      in_circuit_debug && !interruptEntry && !return_from_interrupt && !wrSlow
         |=> $stable(slowdownEn_reg);
   endproperty
   a_debug: assert property (p_debug) else $error("debug changed slowdown");

   property p_slow;
      @(posedge clock) disable iff (sys_rst)
      slowdownEn_reg && !in_circuit_debug && slowCount_reg < ratioMax |=> !cpuCycleEnable;
   endproperty
   a_slow: assert property (p_slow) else $error("cpu cycle not gated");

   property p_wrap;
      @(posedge clock) disable iff (sys_rst)
      slowCount_reg >= ratioMax |=> slowCount_reg == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("slowdown counter did not wrap");

   property p_lpentry;
      @(posedge clock) disable iff (sys_rst)
      state_reg == DIPC_RUN && sleepRequest
         |=> lpSleep_reg == ($past(regulatorPower_reg) && !$past(idleOnSleep_reg));
   endproperty
   a_lpentry: assert property (p_lpentry) else $error("sleep regulator mode wrong");

   property p_normreg;
      @(posedge clock) disable iff (sys_rst)
      !(state_reg == DIPC_SLEEP && lpSleep_reg) |=> !regulatorLowPower;
   endproperty
   a_normreg: assert property (p_normreg) else $error("regulator left normal mode");

   property p_wakeone;
      @(posedge clock) disable iff (sys_rst)
      wakeDone |=> !wakeDone;
   endproperty
   a_wakeone: assert property (p_wakeone) else $error("wake pulse too long");

   property p_upper;
      @(posedge clock) disable iff (sys_rst)
      pready |-> prdata[31:8] == 24'h000000;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");

   property p_slowrsvd;
      @(posedge clock) disable iff (sys_rst)
      pready && !pwrite && paddr == `DIPC_OFF_SLOW |-> !prdata[3];
   endproperty
   a_slowrsvd: assert property (p_slowrsvd) else $error("slowdown bit 3 set");

   property p_idlepor;
      @(posedge clock) powerOnReset |=> !idleOnSleep_reg;
   endproperty
   a_idlepor: assert property (p_idlepor) else $error("idle not cleared");

   property p_idlewarm;
      @(posedge clock) sys_rst && !powerOnReset |=> $stable(idleOnSleep_reg);
   endproperty
   a_idlewarm: assert property (p_idlewarm) else $error("idle lost on reset");

   c_idle: cover property (@(posedge clock) state_reg == DIPC_IDLE);
   c_wake: cover property (@(posedge clock) wakeDone);
   c_slow: cover property (@(posedge clock) slowdownEn_reg && ratio_reg == 3'h7);
   c_lpsleep: cover property (@(posedge clock) regulatorLowPower);
   c_debug: cover property (@(posedge clock) slowdownEn_reg && in_circuit_debug && cpuCycleEnable);
endmodule

// ==== dv/dipc_power_control_tb_top.sv ====
// Self-checking bench for the power-mode control block
`timescale 1ns/1ns
module dipc_power_control_tb_top;
   localparam int WN = 4;
   localparam int WL = 16;
   localparam logic [31:0] EVW [4] = '{32'h60, 32'h40, 32'h10, 32'h40};
   localparam logic [31:0] EVE [4] = '{32'h20, 32'h40, 32'h50, 32'h40};
   logic clock, sys_rst, powerOnReset, psel, penable, pwrite, sleepRequest, wakeEvent;
   logic interruptEntry, return_from_interrupt, in_circuit_debug, err;
   logic cpuCycleEnable, cpuClockRun, periphClockRun, regulatorLowPower, wakeDone;
   logic pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int fails, checked, tn, tl, c;

   dipc_power_control #(.WAKE_NORM(WN), .WAKE_LP_EXTRA(WL)) i_dut (
      .clock, .sys_rst, .powerOnReset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sleepRequest, .wakeEvent, .interruptEntry,
      .return_from_interrupt, .in_circuit_debug, .cpuCycleEnable, .cpuClockRun,
      .periphClockRun, .regulatorLowPower, .wakeDone);

   always #5 clock = ~clock;

   task tally_and_finish;
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; starts just after an edge, ends one idle edge later
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) fails++;
      rdat = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
      apb(1'h0, a, 32'h0);
      chk(nm, rdat, exp);
   endtask

   // CPU cycles granted over a window that spans whole slowdown periods
   task count_run(output int k);
      k = 0;
      repeat (4) @(posedge clock);
      repeat (512) begin
         @(posedge clock);
         if (cpuCycleEnable === 1'h1) k++;
      end
   endtask

   task sleep_wake(input logic [31:0] v, input logic [31:0] s, output int t);
      int w;
      wr(12'h000, v);
      wr(12'h004, s);
      sleepRequest <= 1'h1;
      @(posedge clock);
      sleepRequest <= 1'h0;
      repeat (3) @(posedge clock);
      chk("cpuClockRun", {31'h0, cpuClockRun}, 32'h0);
      chk("periphClockRun", {31'h0, periphClockRun}, {31'h0, s[7]});
      chk("regulatorLowPower", {31'h0, regulatorLowPower}, {31'h0, v[1] & ~s[7]});
      rd(12'h008, {29'h0, v[1] & ~s[7], ~s[7], s[7]}, "status");
      wakeEvent <= 1'h1;
      @(posedge clock);
      wakeEvent <= 1'h0;
      t = 0;
      w = 0;
      while (cpuClockRun !== 1'h1 && t < 200) begin
         @(posedge clock);
         t++;
         if (wakeDone === 1'h1) w++;
      end
      if (t >= 200) fails++;
      chk("wakeDone", w, {31'h0, ~s[7]});
      repeat (2) @(posedge clock);
   endtask

   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end

   initial begin
      clock = 1'h0;
      sys_rst = 1'h1;
      powerOnReset = 1'h1;
      {psel, penable, pwrite, sleepRequest, wakeEvent} = 5'h00;
      {interruptEntry, return_from_interrupt, in_circuit_debug} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fails = 0;
      checked = 0;
      repeat (4) @(posedge clock);
      sys_rst <= 1'h0;
      powerOnReset <= 1'h0;
      @(posedge clock);
      rd(12'h000, 32'h01, "regulator reset");
      chk("pslverr mapped", {31'h0, err}, 32'h0);
      rd(12'h004, 32'h00, "slowdown reset");
      wr(12'h000, 32'hFFFFFFFF);
      rd(12'h000, 32'h03, "regulator mask");
      wr(12'h004, 32'hFFFFFFFF);
      rd(12'h004, 32'hF7, "slowdown mask");
      rd(12'h00C, 32'h0, "unmapped read");
      chk("pslverr", {31'h0, err}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(12'h004, 32'h40 | i);
         count_run(c);
         chk("slowdown count", c, 512 >> (i + 1));
      end
      in_circuit_debug <= 1'h1;
      count_run(c);
      chk("debug count", c, 512);
      rd(12'h004, 32'h47, "debug keeps enable");
      in_circuit_debug <= 1'h0;
      wr(12'h004, 32'h00);
      count_run(c);
      chk("full count", c, 512);
      for (int i = 0; i < 4; i++) begin
         wr(12'h004, EVW[i]);
         if (i < 2)
            interruptEntry <= 1'h1;
         else
            return_from_interrupt <= 1'h1;
         @(posedge clock);
         interruptEntry <= 1'h0;
         return_from_interrupt <= 1'h0;
         @(posedge clock);
         rd(12'h004, EVE[i], "interrupt event");
      end
      sleep_wake(32'h01, 32'h00, tn);
      sleep_wake(32'h03, 32'h00, tl);
      chk("wake extra", tl - tn, WL);
      sleep_wake(32'h03, 32'h80, c);
      wr(12'h004, 32'hF3);
      sys_rst <= 1'h1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'h0;
      @(posedge clock);
      rd(12'h004, 32'h80, "idle kept");
      rd(12'h000, 32'h01, "regulator after reset");
      sys_rst <= 1'h1;
      powerOnReset <= 1'h1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'h0;
      powerOnReset <= 1'h0;
      @(posedge clock);
      rd(12'h004, 32'h00, "idle cleared");
      tally_and_finish();
   end
endmodule
